// >>> rtl/accel_ctrl_regs.sv
// Control register bank: interrupt routing, sync, range, power, AXI4-Lite slave
// Summary of operation
// - Eight-bit routing register; each set bit lets one event drive a pin.
// - Bits 7..4 route activity, overflow, full, ready to pin two; 3..0 to one.
// - Any number of events may be routed to either pin together.
// - Routing register resets to zero, so no event drives a pin.
// - Sync code 00 is internal timing, 11 reserved; field resets to internal.
// - Sync code 01 raises data ready on each external sync pulse.
// - Sync code 10 raises ready 21 to 8204 oscillator cycles after sync.
// - Sync bit 2 takes timing from the external clock input.
// - Range bit 7 selects two-wire speed, 1 high speed; resets high.
// - Range bit 6 sets pin polarity, 0 active low; resets active low.
// - Range field 01/10/11 selects 2/4/8 g; resets to 01.
// - Power bit 2 holds the ready pin at zero.
// - Power bit 1 or standby disables temperature processing.
// - Power bit 0 is standby when set; device starts in standby.
// - Standby stops datapaths, enters low power, resets FIFO pointers.
// - Full event rises when stored samples reach the watermark, 1 to 127.
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module accel_ctrl_regs #(
  parameter logic [13:0] INTERP_MAX_CYCLES = accel_ctrl_pkg::INTERP_MAX_DEFAULT
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [9:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [9:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Event sources from the datapath
  input wire logic sample_strobe,
  input wire logic queue_overflow_event,
  input wire logic motion_event,
  input wire logic [6:0] fifo_level,
  input wire logic [3:0] rate_filter_select,
  // External pins
  input wire logic sync_pin,
  input wire logic outside_clock_pin,
  // Interrupt and ready pins
  output logic irq_pin_one,
  output logic irq_pin_two,
  output logic ready_pin,
  output logic irq,
  // Configuration to the device
  output logic two_wire_speed_select,
  output logic [1:0] range_select,
  output logic outside_clock_select,
  output logic osc_tick,
  output logic temp_enable,
  output logic datapath_run,
  output logic fifo_pointer_reset,
  output logic low_power
);
  // Register state
  logic [7:0] routing, next_routing;
  logic [7:0] sync_reg, next_sync_reg;
  logic [7:0] range_reg, next_range_reg;
  logic [7:0] power_reg, next_power_reg;
  logic [6:0] watermark, next_watermark;
  accel_ctrl_pkg::event_type mask, next_mask, status, next_status, clear, set;
  // Bus state
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [7:0] aw_idx, next_aw_idx;
  logic [7:0] w_data, next_w_data;
  logic w_strb, next_w_strb;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic write_fire;
  // Timing state
  logic [7:0] osc_count, next_osc_count;
  logic [13:0] interp_count, next_interp_count;
  logic next_osc_tick, ready_evt, full_evt, standby;
  logic sync_level, sync_rise, outside_clock_level, outside_clock_rise;
  // Output next values
  logic next_irq_pin_one, next_irq_pin_two, next_ready_pin, next_irq;

  // Known register index
  function automatic logic reg_known(input logic [7:0] idx);
    case (idx)
      accel_ctrl_pkg::IDX_WATERMARK, accel_ctrl_pkg::IDX_ROUTING,
      accel_ctrl_pkg::IDX_SYNC, accel_ctrl_pkg::IDX_RANGE,
      accel_ctrl_pkg::IDX_POWER, accel_ctrl_pkg::IDX_IRQ_STATUS,
      accel_ctrl_pkg::IDX_IRQ_MASK: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : reg_known

  // Interpolation delay grows with the output rate code
  function automatic logic [13:0] interp_delay(input logic [3:0] odr);
    logic [3:0] code;
    code = (odr > accel_ctrl_pkg::ODR_MAX_CODE) ? accel_ctrl_pkg::ODR_MAX_CODE : odr;
    return accel_ctrl_pkg::INTERP_MIN_CYCLES + ((INTERP_MAX_CYCLES
      - accel_ctrl_pkg::INTERP_MIN_CYCLES) >> (accel_ctrl_pkg::ODR_MAX_CODE - code));
  endfunction : interp_delay

  // Pin synchronisers
  pin_sync sync_in (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(sync_pin),
    .level(sync_level),
    .rise(sync_rise)
  );
  pin_sync clock_in (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(outside_clock_pin),
    .level(outside_clock_level),
    .rise(outside_clock_rise)
  );

  assign standby = power_reg[accel_ctrl_pkg::POWER_STANDBY_BIT];

  // Write channel: address and data taken in either order, response after both
  always_comb begin
    next_aw_held = aw_held;
    next_aw_idx = aw_idx;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid && !bready;
    next_bresp = bresp;
    next_routing = routing;
    next_sync_reg = sync_reg;
    next_range_reg = range_reg;
    next_power_reg = power_reg;
    next_watermark = watermark;
    next_mask = mask;
    clear = '0;
    write_fire = aw_held && w_held && !bvalid;
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_aw_idx = awaddr[9:2];
    end
    if (wvalid && wready) begin
      next_w_held = 1'b1;
      next_w_data = wdata[7:0];
      next_w_strb = wstrb[0];
    end
    if (write_fire) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = reg_known(aw_idx) ? accel_ctrl_pkg::RESP_OKAY : accel_ctrl_pkg::RESP_SLVERR;
      if (w_strb) begin
        case (aw_idx)
          accel_ctrl_pkg::IDX_WATERMARK: next_watermark = w_data[6:0];
          accel_ctrl_pkg::IDX_ROUTING: next_routing = w_data;
          accel_ctrl_pkg::IDX_SYNC: next_sync_reg = w_data & accel_ctrl_pkg::WMASK_SYNC;
          accel_ctrl_pkg::IDX_RANGE: next_range_reg = w_data & accel_ctrl_pkg::WMASK_RANGE;
          accel_ctrl_pkg::IDX_POWER: next_power_reg = w_data & accel_ctrl_pkg::WMASK_POWER;
          accel_ctrl_pkg::IDX_IRQ_STATUS: clear = w_data[3:0];
          accel_ctrl_pkg::IDX_IRQ_MASK: next_mask = w_data[3:0];
          default: clear = '0;
        endcase
      end
    end
    next_awready = !next_aw_held;
    next_wready = !next_w_held;
  end

  // Write channel and configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_idx <= 8'h00;
      w_held <= 1'b0;
      w_data <= 8'h00;
      w_strb <= 1'b0;
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= accel_ctrl_pkg::RESP_OKAY;
      routing <= accel_ctrl_pkg::RST_ROUTING;
      sync_reg <= accel_ctrl_pkg::RST_SYNC;
      range_reg <= accel_ctrl_pkg::RST_RANGE;
      power_reg <= accel_ctrl_pkg::RST_POWER;
      watermark <= accel_ctrl_pkg::RST_WATERMARK;
      mask <= accel_ctrl_pkg::RST_IRQ;
    end else begin
      aw_held <= next_aw_held;
      aw_idx <= next_aw_idx;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      routing <= next_routing;
      sync_reg <= next_sync_reg;
      range_reg <= next_range_reg;
      power_reg <= next_power_reg;
      watermark <= next_watermark;
      mask <= next_mask;
    end
  end

  // Read channel: one read at a time, answer the cycle after the address
  always_comb begin
    next_rvalid = rvalid && !rready;
    next_rdata = rdata;
    next_rresp = rresp;
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp = reg_known(araddr[9:2]) ? accel_ctrl_pkg::RESP_OKAY
                                          : accel_ctrl_pkg::RESP_SLVERR;
      case (araddr[9:2])
        accel_ctrl_pkg::IDX_WATERMARK: next_rdata = {25'h000_0000, watermark};
        accel_ctrl_pkg::IDX_ROUTING: next_rdata = {24'h00_0000, routing};
        accel_ctrl_pkg::IDX_SYNC: next_rdata = {24'h00_0000, sync_reg};
        accel_ctrl_pkg::IDX_RANGE: next_rdata = {24'h00_0000, range_reg};
        accel_ctrl_pkg::IDX_POWER: next_rdata = {24'h00_0000, power_reg};
        accel_ctrl_pkg::IDX_IRQ_STATUS: next_rdata = {28'h000_0000, status};
        accel_ctrl_pkg::IDX_IRQ_MASK: next_rdata = {28'h000_0000, mask};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
    next_arready = !next_rvalid;
  end

  // Read channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= accel_ctrl_pkg::RESP_OKAY;
    end else begin
      arready <= next_arready;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // Timing and events; standby clears all event state
  always_comb begin
    next_osc_count = (osc_count == 8'h00) ? accel_ctrl_pkg::OSC_DIV - 8'h01 : osc_count - 8'h01;
    next_osc_tick = sync_reg[accel_ctrl_pkg::SYNC_CLK_BIT] ? outside_clock_rise
                                                           : (osc_count == 8'h00);
    next_interp_count = interp_count;
    ready_evt = 1'b0;
    case (sync_reg[1:0])
      accel_ctrl_pkg::SYNC_INTERNAL: ready_evt = sample_strobe;
      accel_ctrl_pkg::SYNC_EXT_DIRECT: ready_evt = sync_rise;
      accel_ctrl_pkg::SYNC_EXT_INTERP: begin
        if (osc_tick && interp_count != 14'h0000) begin
          next_interp_count = interp_count - 14'h0001;
          ready_evt = (interp_count == 14'h0001);
        end
        if (sync_rise) begin
          next_interp_count = interp_delay(rate_filter_select);
        end
      end
      default: ready_evt = 1'b0; // Reserved code raises nothing
    endcase
    // Level watermark compare; zero watermark never fires
    full_evt = (watermark != 7'h00) && (fifo_level >= watermark);
    set = {motion_event, queue_overflow_event, full_evt, ready_evt};
    // Set wins over a same-cycle clear
    next_status = (status & ~clear) | set;
    if (standby) begin
      next_status = '0;
      next_interp_count = 14'h0000;
    end
    // Several routed events OR together on each pin
    next_irq_pin_one = range_reg[accel_ctrl_pkg::RANGE_POL_BIT] ~^ (|(routing[3:0] & status));
    next_irq_pin_two = range_reg[accel_ctrl_pkg::RANGE_POL_BIT] ~^ (|(routing[7:4] & status));
    next_ready_pin = status.ready && !power_reg[accel_ctrl_pkg::POWER_READY_LOW_BIT];
    next_irq = |(status & mask);
  end

  // Event state and pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_count <= 8'h00;
      osc_tick <= 1'b0;
      interp_count <= 14'h0000;
      status <= accel_ctrl_pkg::RST_IRQ;
      irq_pin_one <= 1'b1;
      irq_pin_two <= 1'b1;
      ready_pin <= 1'b0;
      irq <= 1'b0;
    end else begin
      osc_count <= next_osc_count;
      osc_tick <= next_osc_tick;
      interp_count <= next_interp_count;
      status <= next_status;
      irq_pin_one <= next_irq_pin_one;
      irq_pin_two <= next_irq_pin_two;
      ready_pin <= next_ready_pin;
      irq <= next_irq;
    end
  end

  // Configuration outputs, one cycle behind the registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      two_wire_speed_select <= 1'b1;
      range_select <= accel_ctrl_pkg::RANGE_2G;
      outside_clock_select <= 1'b0;
      temp_enable <= 1'b0;
      datapath_run <= 1'b0;
      fifo_pointer_reset <= 1'b1;
      low_power <= 1'b1;
    end else begin
      two_wire_speed_select <= range_reg[accel_ctrl_pkg::RANGE_SPEED_BIT];
      range_select <= range_reg[1:0];
      outside_clock_select <= sync_reg[accel_ctrl_pkg::SYNC_CLK_BIT];
      temp_enable <= !standby && !power_reg[accel_ctrl_pkg::POWER_TEMP_OFF_BIT];
      datapath_run <= !standby;
      fifo_pointer_reset <= standby;
      low_power <= standby;
    end
  end

  // Checks
  default clocking chk @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_routing_reset: assert property (disable iff (1'b0) !aresetn |=> routing == 8'h00)
    else $error("routing not zero after reset");
  a_pin_one_or: assert property (##1 irq_pin_one ==
    ($past(range_reg[6]) ~^ (|($past(routing[3:0]) & $past(status)))))
    else $error("pin one does not follow routed events");
  a_pin_two_or: assert property (##1 irq_pin_two ==
    ($past(range_reg[6]) ~^ (|($past(routing[7:4]) & $past(status)))))
    else $error("pin two does not follow routed events");
  a_ready_forced: assert property (power_reg[2] |=> !ready_pin)
    else $error("ready pin not held low");
  a_temp_off: assert property ((power_reg[1] || standby) |=> !temp_enable)
    else $error("temperature still enabled");
  a_standby_reset: assert property (standby |=> fifo_pointer_reset && !datapath_run
    && status == 4'h0 && low_power)
    else $error("standby did not stop the datapath");
  a_direct_ready: assert property (!standby && sync_reg[1:0] == 2'h1 && sync_rise
    && $stable(power_reg) |=> status.ready)
    else $error("sync pulse did not raise ready");
  a_interp_load: assert property (!standby && sync_reg[1:0] == 2'h2 && sync_rise
    |=> interp_count >= 14'h000e && interp_count <= INTERP_MAX_CYCLES)
    else $error("interpolation delay out of range");
  a_clock_source: assert property (sync_reg[2] && !outside_clock_rise |=> !osc_tick)
    else $error("tick without external clock edge");
  a_speed_bit: assert property (##1 two_wire_speed_select == $past(range_reg[7]))
    else $error("speed select does not follow register");
  a_full_mark: assert property (!standby && watermark != 7'h00 && fifo_level >= watermark
    |=> status.full)
    else $error("watermark reached without full event");
  a_write_resp: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");

  c_interp_ready: cover property (sync_reg[1:0] == 2'h2 && ready_evt);
  c_both_pins: cover property (routing[3:0] != 4'h0 && routing[7:4] != 4'h0 && status != 4'h0);
  c_set_and_clear: cover property (write_fire && clear != 4'h0 && (set & clear) != 4'h0);
endmodule : accel_ctrl_regs
`default_nettype wire

// >>> pkg/accel_ctrl_pkg.sv
// Package: register map, field layout, reset values and timing of the control bank
package accel_ctrl_pkg;
  // Register indices; the bus byte address is four times the index
  localparam logic [7:0] IDX_WATERMARK = 8'h29;
  localparam logic [7:0] IDX_ROUTING = 8'h2a;
  localparam logic [7:0] IDX_SYNC = 8'h2b;
  localparam logic [7:0] IDX_RANGE = 8'h2c;
  localparam logic [7:0] IDX_POWER = 8'h2d;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h30;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h31;

  // Values after reset
  localparam logic [7:0] RST_ROUTING = 8'h00;
  localparam logic [7:0] RST_SYNC = 8'h00;
  localparam logic [7:0] RST_RANGE = 8'h81;
  localparam logic [7:0] RST_POWER = 8'h01;
  localparam logic [6:0] RST_WATERMARK = 7'h60;
  localparam logic [3:0] RST_IRQ = 4'h0;

  // Writable bits; reserved bits stay zero
  localparam logic [7:0] WMASK_SYNC = 8'h07;
  localparam logic [7:0] WMASK_RANGE = 8'hc3;
  localparam logic [7:0] WMASK_POWER = 8'h07;

  // Field positions
  localparam int SYNC_CLK_BIT = 2;
  localparam int RANGE_SPEED_BIT = 7;
  localparam int RANGE_POL_BIT = 6;
  localparam int POWER_READY_LOW_BIT = 2;
  localparam int POWER_TEMP_OFF_BIT = 1;
  localparam int POWER_STANDBY_BIT = 0;

  // Synchronisation codes
  localparam logic [1:0] SYNC_INTERNAL = 2'h0;
  localparam logic [1:0] SYNC_EXT_DIRECT = 2'h1;
  localparam logic [1:0] SYNC_EXT_INTERP = 2'h2;

  // Full scale codes
  localparam logic [1:0] RANGE_2G = 2'h1;
  localparam logic [1:0] RANGE_4G = 2'h2;
  localparam logic [1:0] RANGE_8G = 2'h3;

  // Oscillator timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int OSC_PERIOD_NS = 1000;
  localparam logic [7:0] OSC_DIV = 8'(OSC_PERIOD_NS / CLK_PERIOD_NS);
  localparam logic [13:0] INTERP_MIN_CYCLES = 14'h000e;
  localparam logic [13:0] INTERP_MAX_DEFAULT = 14'h200c;
  localparam logic [3:0] ODR_MAX_CODE = 4'ha;

  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Event sources, in routing bit order
  typedef struct packed {
    logic activity;
    logic overflow;
    logic full;
    logic ready;
  } event_type;
endpackage : accel_ctrl_pkg

// >>> rtl/pin_sync.sv
// Three-stage pin synchroniser with agreement filter and rise pulse
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pin and result
  input wire logic pin,
  output logic level,
  output logic rise
);
  logic [2:0] stage;
  logic [2:0] next_stage;
  logic next_level;
  logic next_rise;

  // Level changes only when the second and third stages agree
  always_comb begin
    next_stage = {stage[1:0], pin};
    next_level = level;
    next_rise = 1'b0;
    if (stage[1] == stage[2]) begin
      next_level = stage[2];
      next_rise = stage[2] && !level;
    end
  end

  // Stage 0 feeds only stage 1 to keep metastability contained
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage <= 3'h0;
      level <= 1'b0;
      rise <= 1'b0;
    end else begin
      stage <= next_stage;
      level <= next_level;
      rise <= next_rise;
    end
  end
endmodule : pin_sync
`default_nettype wire

// >>> testbench/host_master.sv
// Host model: AXI4-Lite master that reaches the control bank
`timescale 1ns/10ps
`default_nettype none
module host_master (
  // Clock
  input wire logic aclk,
  // Write channels
  output logic [9:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  // Read channels
  output logic [9:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  int hangs;
  // Idle bus at time zero
  initial begin
    hangs = 0;
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // One write; payload inverted once released so stale values never pass
  task automatic write_reg(input logic [7:0] idx, input logic [7:0] val, input logic strb,
                           output logic [1:0] resp);
    int n;
    logic got;
    got = 1'b0;
    resp = 2'h3;
    @(posedge aclk);
    awaddr <= {idx, 2'h0};
    awvalid <= 1'b1;
    wdata <= {24'h00_0000, val};
    wstrb <= {3'h0, strb};
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50 && !got; n++) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr <= ~awaddr;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata <= ~wdata;
      end
      if (bvalid) begin
        got = 1'b1;
        resp = bresp;
      end
    end
    bready <= 1'b0;
    if (!got) hangs++;
  endtask : write_reg
  // One read; rready held until the answer is sampled
  task automatic read_reg(input logic [7:0] idx, output logic [31:0] data,
                          output logic [1:0] resp);
    int n;
    logic got;
    got = 1'b0;
    data = 32'h0000_0000;
    resp = 2'h3;
    @(posedge aclk);
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50 && !got; n++) begin
      @(posedge aclk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr <= ~araddr;
      end
      if (rvalid) begin
        got = 1'b1;
        data = rdata;
        resp = rresp;
      end
    end
    rready <= 1'b0;
    if (!got) hangs++;
  endtask : read_reg
endmodule : host_master
`default_nettype wire

// >>> testbench/accel_ctrl_regs_bench.sv
// Bench for the control bank: register table, routing, events, sync, power
`timescale 1ns/10ps
`default_nettype none
module accel_ctrl_regs_bench;
  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] val;
    logic strb;
    logic [1:0] resp;
    logic [7:0] rd;
  } row_type;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [9:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic sample_strobe, queue_overflow_event, motion_event, sync_pin;
  logic [6:0] fifo_level;
  logic [3:0] rate_filter_select;
  logic [2:0] div = 3'h0;
  logic pin_one, pin_two, ready_pin, irq, speed, ext_sel, tick, temp_en, run, fptr, lowp;
  logic [1:0] range_select;
  int num_errors = 0;
  int samples_checked = 0;
  int i;
  int n;
  logic [3:0] od [3] = '{4'h0, 4'ha, 4'h0};
  int w1 [3] = '{60, 400, 213};
  int w2 [3] = '{150, 600, 1900};
  logic [7:0] sy [3] = '{8'h06, 8'h06, 8'h02};
  row_type rows [8] = '{
    '{8'h2a, 8'ha5, 1'b1, 2'h0, 8'ha5}, '{8'h2b, 8'hff, 1'b1, 2'h0, 8'h07},
    '{8'h2c, 8'hff, 1'b1, 2'h0, 8'hc3}, '{8'h2d, 8'hfe, 1'b1, 2'h0, 8'h06},
    '{8'h2d, 8'h01, 1'b0, 2'h0, 8'h06}, '{8'h2e, 8'h55, 1'b1, 2'h2, 8'h00},
    '{8'h29, 8'hff, 1'b1, 2'h0, 8'h7f}, '{8'h31, 8'h0f, 1'b1, 2'h0, 8'h0f}};
  // Clock and an outside clock of eight cycles
  always #4 aclk = ~aclk;
  always @(posedge aclk) div <= div + 3'h1;
  accel_ctrl_regs #(.INTERP_MAX_CYCLES(14'h0064)) uut (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .sample_strobe(sample_strobe),
    .queue_overflow_event(queue_overflow_event), .motion_event(motion_event),
    .fifo_level(fifo_level), .rate_filter_select(rate_filter_select), .sync_pin(sync_pin),
    .outside_clock_pin(div[2]), .irq_pin_one(pin_one), .irq_pin_two(pin_two),
    .ready_pin(ready_pin), .irq(irq), .two_wire_speed_select(speed),
    .range_select(range_select), .outside_clock_select(ext_sel), .osc_tick(tick),
    .temp_enable(temp_en), .datapath_run(run), .fifo_pointer_reset(fptr), .low_power(lowp));
  host_master host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  // Verdict and end of run
  task automatic give_verdict();
    num_errors = num_errors + host.hangs;
    $display("checks %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check
  // Bus helpers; a hung transfer ends the run at once
  task automatic wr(input logic [7:0] idx, input logic [7:0] val);
    host.write_reg(idx, val, 1'b1, r);
    check("bresp", 32'h0000_0000, r);
    if (host.hangs != 0) give_verdict();
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    host.read_reg(idx, d, r);
    check("rdata", exp, d);
    check("rresp", 32'h0000_0000, r);
    if (host.hangs != 0) give_verdict();
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc
  // One-cycle event pulse: bit3 motion, 2 overflow, 1 full, 0 ready
  task automatic fire(input logic [3:0] ev);
    @(posedge aclk);
    {motion_event, queue_overflow_event, sample_strobe} <= {ev[3], ev[2], ev[0]};
    fifo_level <= {6'h00, ev[1]};
    @(posedge aclk);
    {motion_event, queue_overflow_event, sample_strobe, fifo_level} <= '0;
    cyc(3);
  endtask : fire
  // Config goes in only while in standby
  task automatic cfg(input logic [7:0] idx, input logic [7:0] val);
    wr(8'h2d, 8'h01);
    wr(idx, val);
    wr(8'h2d, 8'h00);
  endtask : cfg
  task automatic pulse_sync();
    @(posedge aclk) sync_pin <= 1'b1;
    cyc(4);
    sync_pin <= 1'b0;
  endtask : pulse_sync
  initial begin
    {sample_strobe, queue_overflow_event, motion_event, sync_pin} = '0;
    fifo_level = 7'h00;
    rate_filter_select = 4'h0;
    cyc(3);
    aresetn <= 1'b1;
    for (i = 0; i < 8; i++) begin
      host.write_reg(rows[i].idx, rows[i].val, rows[i].strb, r);
      check("bresp", rows[i].resp, r);
      host.read_reg(rows[i].idx, d, r);
      check("rdata", rows[i].rd, d);
      check("rresp", rows[i].resp, r);
    end
    cyc(2);
    check("temp_enable", 0, temp_en);
    check("datapath_run", 1, run);
    check("range_select", 3, range_select);
    check("outside_clock_select", 1, ext_sel);
    $display("table test done");
    aresetn <= 1'b0;
    cyc(3);
    check("irq_pin_one", 1, pin_one);
    check("irq_pin_two", 1, pin_two);
    check("speed", 1, speed);
    check("range_select", 1, range_select);
    check("low_power", 1, lowp);
    check("fifo_pointer_reset", 1, fptr);
    check("temp_enable", 0, temp_en);
    aresetn <= 1'b1;
    rd(8'h2a, 8'h00);
    rd(8'h2b, 8'h00);
    rd(8'h2c, 8'h81);
    rd(8'h2d, 8'h01);
    $display("reset test done");
    wr(8'h29, 8'h01);
    for (i = 0; i < 8; i++) begin
      cfg(8'h2a, 8'h01 << i);
      fire(4'h1 << (i % 4));
      check("irq_pin_one", i >= 4, pin_one);
      check("irq_pin_two", i < 4, pin_two);
    end
    $display("routing test done");
    cfg(8'h2a, 8'hff);
    wr(8'h31, 8'h08);
    fire(4'h4);
    check("irq", 0, irq);
    check("irq_pin_two", 0, pin_two);
    fire(4'h8);
    check("irq", 1, irq);
    wr(8'h30, 8'h08);
    cyc(2);
    check("irq", 0, irq);
    check("irq_pin_one", 0, pin_one);
    rd(8'h30, 8'h04);
    wr(8'h30, 8'h04);
    cyc(2);
    check("irq_pin_one", 1, pin_one);
    cfg(8'h2c, 8'h41);
    cyc(2);
    check("irq_pin_one", 0, pin_one);
    check("speed", 0, speed);
    fire(4'h4);
    check("irq_pin_two", 1, pin_two);
    fire(4'h1);
    check("ready_pin", 1, ready_pin);
    wr(8'h2d, 8'h04);
    cyc(2);
    check("ready_pin", 0, ready_pin);
    check("temp_enable", 1, temp_en);
    wr(8'h2d, 8'h02);
    cyc(2);
    check("temp_enable", 0, temp_en);
    $display("event test done");
    cfg(8'h29, 8'h60);
    @(posedge aclk) fifo_level <= 7'h5f;
    cyc(3);
    rd(8'h30, 8'h00);
    fifo_level <= 7'h60;
    cyc(3);
    rd(8'h30, 8'h02);
    fifo_level <= 7'h00;
    cfg(8'h2b, 8'h01);
    pulse_sync();
    cyc(8);
    rd(8'h30, 8'h01);
    $display("watermark and direct sync test done");
    for (i = 0; i < 3; i++) begin
      rate_filter_select <= od[i];
      cfg(8'h2b, sy[i]);
      pulse_sync();
      cyc(w1[i]);
      rd(8'h30, 8'h00);
      cyc(w2[i]);
      rd(8'h30, 8'h01);
    end
    // Internal divider ticks once per 125 cycles, so any 250-cycle window holds two
    n = 0;
    repeat (250) begin
      @(posedge aclk);
      n = n + tick;
    end
    check("osc_tick", 2, n);
    $display("interpolated sync test done");
    give_verdict();
  end
endmodule : accel_ctrl_regs_bench
`default_nettype wire
